/* mrxa_pkg.sv */
package mrxa_pkg;

	localparam int NCH = 4;
	localparam int QCH = 2;
	localparam int GW  = 10;
	localparam int WW  = 40;

	localparam logic [19:0] ADDR_MODE_A  = 20'h30811;
	localparam logic [19:0] ADDR_MODE_B  = 20'h30911;
	localparam logic [19:0] ADDR_LEGJ_A  = 20'h30810;
	localparam logic [19:0] ADDR_LEGJ_B  = 20'h30910;
	localparam logic [19:0] ADDR_TXSRC_A = 20'h30812;
	localparam logic [19:0] ADDR_TXSRC_B = 20'h30912;
	localparam logic [19:0] ADDR_STAT_A  = 20'h30813;
	localparam logic [19:0] ADDR_STAT_B  = 20'h30913;
	localparam logic [19:0] ADDR_CFG0    = 20'h30820;
	localparam logic [19:0] ADDR_LEG [8] = '{20'h30002, 20'h30012, 20'h30102, 20'h30112,
	                                         20'h30003, 20'h30013, 20'h30103, 20'h30113};

	localparam logic [7:0] MODE_NONE = 8'h00;
	localparam logic [7:0] MODE_TWIN = 8'h0A;
	localparam logic [7:0] MODE_FOUR = 8'h0F;

	localparam int LEG_PD_BIT   = 1;
	localparam int LEGJ_LO      = 4;
	localparam int LEGJ_HI      = 5;
	localparam int CFG_DEC      = 0;
	localparam int CFG_CVSEL    = 1;
	localparam int CFG_FULL     = 2;
	localparam int CFG_MEMB     = 3;
	localparam int STAT_OVF     = 0;
	localparam int STAT_OOS     = 1;
	localparam int STAT_DONE    = 2;
	localparam int STAT_ALIGNED = 3;

	localparam logic [7:0] MODE_RST  = 8'h00;
	localparam logic [3:0] CFG_RST   = 4'hB;
	localparam logic [7:0] ALIGN_CNT = 8'h10;

	typedef enum logic [1:0] {GS_IDLE, GS_COUNT, GS_DONE} mrxa_grp_st_t;

endpackage : mrxa_pkg

/* mrxa_word_fmt.sv */
module mrxa_word_fmt
	import mrxa_pkg::*;
(
	input  wire logic [WW-1:0] raw,
	input  wire logic [31:0]   data,
	input  wire logic [3:0]    kflag,
	input  wire logic [3:0]    cv,
	input  wire logic          dec_en,
	input  wire logic          cv_sel,
	input  wire logic          chalgn,
	input  wire logic          st_oos,
	input  wire logic          st_grp_done,
	input  wire logic          st_all_done,
	input  wire logic          st_ovf,
	output logic [WW-1:0]      word
);

	logic [3:0] stat;

	// Status slots replace violation flags while aligned
	assign stat = {st_oos, st_grp_done, st_all_done, st_ovf};

	always_comb begin
		word = raw;
		if (dec_en) begin
			for (int g = 0; g < 4; g++) begin
				word[g*GW+:8]   = data[g*8+:8];
				word[g*GW+8]    = kflag[g];
				if (chalgn)
					word[g*GW+9] = stat[g];
				else
					word[g*GW+9] = cv_sel & cv[g];
			end
		end
	end

endmodule : mrxa_word_fmt

/* mrxa_core.sv */
// Function
// - Each block picks its own rate
// - Unaligned channels pick rate individually
// - Legacy power-down bits, reset zero, writable
// - Legacy group-join bits reset to zero
// - Mode field decodes none, twin, four
// - One 40-bit word per channel, raw/decoded
// - Decoded group: data, control flag, violation flag
// - Done flags rise at counter zero
// - Raw code-groups packed high to low
// - Violation flag, control flag, data layout
// - Aligned mode: status replaces violation bits
// - Channels read on their quad's clock
// - One muxed transmit clock per quad
// - Rate selectable per channel by register
// - Quarter reference half-rate, half full-rate
// - Removing member keeps others aligned
// - Group overflow and out-of-sync flags
module mrxa_core
	import mrxa_pkg::*;
#(
	parameter logic [7:0] ALIGN_WINDOW = ALIGN_CNT
)(
	input  wire logic               CLK,
	input  wire logic               RST,
	input  wire logic [19:0]        REG_ADDR,
	input  wire logic [7:0]         REG_WDATA,
	input  wire logic               REG_WR,
	input  wire logic               REG_RD,
	output logic      [7:0]         REG_RDATA,
	input  wire logic               RX_READ_CLOCK_A,
	input  wire logic               RX_READ_CLOCK_B,
	input  wire logic               REF_CLOCK_A,
	input  wire logic               REF_CLOCK_B,
	input  wire logic [NCH*WW-1:0]  RX_RAW,
	input  wire logic [NCH*32-1:0]  RX_DATA,
	input  wire logic [NCH*4-1:0]   RX_K,
	input  wire logic [NCH*4-1:0]   RX_CV,
	input  wire logic [NCH-1:0]     RX_ALIGN_CHAR,
	output logic      [NCH*WW-1:0]  RX_WORD_OUT,
	output logic      [NCH-1:0]     RX_WORD_VALID,
	output logic                    TX_CLOCK_RETURN_A,
	output logic                    TX_CLOCK_RETURN_B,
	output logic      [7:0]         LEGACY_POWER_DOWN,
	output logic      [3:0]         LEGACY_GROUP_JOIN
);

	localparam int LW = NCH * (WW + 32 + 4 + 4 + 1);

	// Lane inputs come from the read-clock domain: two flops first
	logic [LW-1:0]      lane_s1_r;
	logic [LW-1:0]      lane_s2_r;
	logic [3:0]         pin_s1_r;
	logic [3:0]         pin_s2_r;
	logic [3:0]         pin_s3_r;
	logic [3:0]         pin_edge;
	logic [NCH*WW-1:0]  raw_s;
	logic [NCH*32-1:0]  data_s;
	logic [NCH*4-1:0]   k_s;
	logic [NCH*4-1:0]   cv_s;
	logic [NCH-1:0]     achar_s;

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			lane_s1_r <= '0;
			lane_s2_r <= '0;
			pin_s1_r  <= 4'h0;
			pin_s2_r  <= 4'h0;
			pin_s3_r  <= 4'h0;
		end else begin
			lane_s1_r <= {RX_ALIGN_CHAR, RX_CV, RX_K, RX_DATA, RX_RAW};
			lane_s2_r <= lane_s1_r;
			pin_s1_r  <= {REF_CLOCK_B, REF_CLOCK_A, RX_READ_CLOCK_B, RX_READ_CLOCK_A};
			pin_s2_r  <= pin_s1_r;
			pin_s3_r  <= pin_s2_r;
		end
	end

	assign pin_edge = pin_s2_r & ~pin_s3_r;
	assign {achar_s, cv_s, k_s, data_s, raw_s} = lane_s2_r;

	// Register file
	logic [7:0]     mode_a_r;
	logic [7:0]     mode_b_r;
	logic [1:0]     txsrc_a_r;
	logic [1:0]     txsrc_b_r;
	logic [7:0]     leg_pd_r;
	logic [3:0]     leg_join_r;
	logic [3:0]     cfg_r [NCH];
	logic [7:0]     rdata_r;
	logic [7:0]     leg_hit;
	logic [NCH-1:0] cfg_hit;
	logic           wr_mode_a;
	logic           wr_mode_b;

	always_comb begin
		for (int i = 0; i < 8; i++)
			leg_hit[i] = (REG_ADDR == ADDR_LEG[i]);
		for (int c = 0; c < NCH; c++)
			cfg_hit[c] = (REG_ADDR == ADDR_CFG0 + 20'(c));
	end
	assign wr_mode_a = REG_WR && REG_ADDR == ADDR_MODE_A;
	assign wr_mode_b = REG_WR && REG_ADDR == ADDR_MODE_B;
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			mode_a_r   <= MODE_RST;
			mode_b_r   <= MODE_RST;
			txsrc_a_r  <= 2'h0;
			txsrc_b_r  <= 2'h0;
			leg_pd_r   <= 8'h00;
			leg_join_r <= 4'h0;
			for (int c = 0; c < NCH; c++)
				cfg_r[c] <= CFG_RST;
		end else if (REG_WR) begin
			if (wr_mode_a)
				mode_a_r <= REG_WDATA;
			if (wr_mode_b)
				mode_b_r <= REG_WDATA;
			if (REG_ADDR == ADDR_TXSRC_A)
				txsrc_a_r <= REG_WDATA[1:0];
			if (REG_ADDR == ADDR_TXSRC_B)
				txsrc_b_r <= REG_WDATA[1:0];
			if (REG_ADDR == ADDR_LEGJ_A)
				leg_join_r[1:0] <= REG_WDATA[LEGJ_HI:LEGJ_LO];
			if (REG_ADDR == ADDR_LEGJ_B)
				leg_join_r[3:2] <= REG_WDATA[LEGJ_HI:LEGJ_LO];
			for (int i = 0; i < 8; i++)
				if (leg_hit[i])
					leg_pd_r[i] <= REG_WDATA[LEG_PD_BIT];
			for (int c = 0; c < NCH; c++)
				if (cfg_hit[c])
					cfg_r[c] <= REG_WDATA[3:0];
		end
	end

	// Group decode: group 0 is quad A (or all four), group 1 is quad B
	logic           four_mode;
	logic [NCH-1:0] gmask [2];
	logic [NCH-1:0] member_en;
	logic [NCH-1:0] gact [2];
	logic [NCH-1:0] chalgn;

	always_comb begin
		for (int c = 0; c < NCH; c++)
			member_en[c] = cfg_r[c][CFG_MEMB];
	end

	assign four_mode = (mode_a_r == MODE_FOUR);
	assign gmask[0]  = four_mode ? 4'hF : (mode_a_r == MODE_TWIN ? 4'h3 : 4'h0);
	assign gmask[1]  = (!four_mode && mode_b_r == MODE_TWIN) ? 4'hC : 4'h0;
	assign gact[0]   = gmask[0] & member_en;
	assign gact[1]   = gmask[1] & member_en;
	assign chalgn    = gact[0] | gact[1];

	// Alignment window per group
	mrxa_grp_st_t gst_r [2];
	logic [7:0]   gcnt_r [2];
	logic [NCH-1:0] gseen_r [2];
	logic [1:0]   ovf_r;
	logic [1:0]   oos_r;
	logic [1:0]   done_r;
	logic [1:0]   aligned_r;
	logic [1:0]   gtick;
	logic [1:0]   gresync;
	logic [NCH-1:0] ghit [2];
	logic [NCH-1:0] gseen_nxt [2];
	assign gtick   = pin_edge[1:0];
	assign gresync = {wr_mode_b | wr_mode_a, wr_mode_a};
	always_comb begin
		for (int g = 0; g < 2; g++) begin
			ghit[g]      = achar_s & gact[g];
			gseen_nxt[g] = gseen_r[g] | ghit[g];
		end
	end

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			for (int g = 0; g < 2; g++) begin
				gst_r[g]   <= GS_IDLE;
				gcnt_r[g]  <= 8'h00;
				gseen_r[g] <= '0;
			end
			ovf_r     <= 2'h0;
			oos_r     <= 2'h0;
			done_r    <= 2'h0;
			aligned_r <= 2'h0;
		end else begin
			for (int g = 0; g < 2; g++) begin
				if (gresync[g] || gact[g] == '0) begin
					gst_r[g]     <= GS_IDLE;
					gseen_r[g]   <= '0;
					ovf_r[g]     <= 1'b0;
					oos_r[g]     <= 1'b0;
					done_r[g]    <= 1'b0;
					aligned_r[g] <= 1'b0;
				end else if (gtick[g]) begin
					case (gst_r[g])
						GS_IDLE: begin
							if (ghit[g] != '0) begin
								gst_r[g]   <= GS_COUNT;
								gcnt_r[g]  <= ALIGN_WINDOW;
								gseen_r[g] <= ghit[g];
							end
						end
						GS_COUNT: begin
							gseen_r[g] <= gseen_nxt[g];
							// Repeat before all arrive would overrun the skew FIFO
							if ((ghit[g] & gseen_r[g]) != '0 && (gseen_r[g] & gact[g]) != gact[g])
								ovf_r[g] <= 1'b1;
							if ((gseen_nxt[g] & gact[g]) == gact[g])
								aligned_r[g] <= 1'b1;
							gcnt_r[g] <= gcnt_r[g] - 8'h01;
							if (gcnt_r[g] == 8'h01) begin
								gst_r[g]  <= GS_DONE;
								done_r[g] <= 1'b1;
								oos_r[g]  <= (gseen_nxt[g] & gact[g]) != gact[g];
							end
						end
						GS_DONE: gseen_r[g] <= gseen_r[g] & gact[g];
						default: gst_r[g] <= GS_IDLE;
					endcase
				end
			end
		end
	end

	// Word formatting and capture on the quad's read clock
	logic [WW-1:0]  word_fmt [NCH];
	logic [NCH-1:0] cap_en;
	logic [NCH-1:0] sgrp;

	for (genvar c = 0; c < NCH; c++) begin : g_ch
		// Four-channel mode keeps all status in group 0
		assign sgrp[c]   = (c >= QCH) && !four_mode;
		assign cap_en[c] = pin_edge[c / QCH];
		mrxa_word_fmt u_fmt (
			.raw         (raw_s[c*WW+:WW]),
			.data        (data_s[c*32+:32]),
			.kflag       (k_s[c*4+:4]),
			.cv          (cv_s[c*4+:4]),
			.dec_en      (cfg_r[c][CFG_DEC]),
			.cv_sel      (cfg_r[c][CFG_CVSEL]),
			.chalgn      (chalgn[c]),
			.st_oos      (oos_r[sgrp[c]]),
			.st_grp_done (done_r[sgrp[c]]),
			.st_all_done (four_mode & done_r[0]),
			.st_ovf      (ovf_r[sgrp[c]]),
			.word        (word_fmt[c])
		);
	end

	logic [NCH*WW-1:0] word_r;
	logic [NCH-1:0]    valid_r;

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			word_r  <= '0;
			valid_r <= '0;
		end else begin
			for (int c = 0; c < NCH; c++) begin
				valid_r[c] <= cap_en[c];
				if (cap_en[c])
					word_r[c*WW+:WW] <= word_fmt[c];
			end
		end
	end

	// Transmit clock return: divide the sampled reference per source rate
	logic [1:0] txdiv_r;
	logic [1:0] txclk_r;
	logic [1:0] src_full;
	assign src_full[0] = cfg_r[txsrc_a_r[0]][CFG_FULL];
	assign src_full[1] = cfg_r[2 + 32'(txsrc_b_r[0])][CFG_FULL];
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			txdiv_r <= 2'h0;
			txclk_r <= 2'h0;
		end else begin
			for (int q = 0; q < 2; q++) begin
				if (pin_edge[2 + q]) begin
					// Toggle per ref edge gives /2, every second edge gives /4
					txdiv_r[q] <= ~txdiv_r[q];
					if (src_full[q] || txdiv_r[q])
						txclk_r[q] <= ~txclk_r[q];
				end
			end
		end
	end

	// Read-back; unmapped addresses read zero
	logic [7:0] rd_mux;
	logic [7:0] stat_a;
	logic [7:0] stat_b;
	logic [7:0] leg_rd;
	logic [7:0] cfg_rd;
	assign stat_a = {4'h0, aligned_r[0], done_r[0], oos_r[0], ovf_r[0]};
	assign stat_b = {4'h0, aligned_r[1], done_r[1], oos_r[1], ovf_r[1]};
	always_comb begin
		leg_rd = 8'h00;
		cfg_rd = 8'h00;
		for (int i = 0; i < 8; i++)
			if (leg_hit[i])
				leg_rd = {6'h00, leg_pd_r[i], 1'b0};
		for (int c = 0; c < NCH; c++)
			if (cfg_hit[c])
				cfg_rd = {4'h0, cfg_r[c]};
	end

	assign rd_mux = (REG_ADDR == ADDR_MODE_A)  ? mode_a_r :
	                (REG_ADDR == ADDR_MODE_B)  ? mode_b_r :
	                (REG_ADDR == ADDR_TXSRC_A) ? {6'h00, txsrc_a_r} :
	                (REG_ADDR == ADDR_TXSRC_B) ? {6'h00, txsrc_b_r} :
	                (REG_ADDR == ADDR_LEGJ_A)  ? {2'h0, leg_join_r[1:0], 4'h0} :
	                (REG_ADDR == ADDR_LEGJ_B)  ? {2'h0, leg_join_r[3:2], 4'h0} :
	                (REG_ADDR == ADDR_STAT_A)  ? stat_a :
	                (REG_ADDR == ADDR_STAT_B)  ? stat_b :
	                (leg_rd | cfg_rd);

	always_ff @(posedge CLK or posedge RST) begin
		if (RST)
			rdata_r <= 8'h00;
		else if (REG_RD)
			rdata_r <= rd_mux;
	end

	assign REG_RDATA         = rdata_r;
	assign RX_WORD_OUT       = word_r;
	assign RX_WORD_VALID     = valid_r;
	assign TX_CLOCK_RETURN_A = txclk_r[0];
	assign TX_CLOCK_RETURN_B = txclk_r[1];
	assign LEGACY_POWER_DOWN = leg_pd_r;
	assign LEGACY_GROUP_JOIN = leg_join_r;

endmodule : mrxa_core

/* mrxa_core_sva.sv */
module mrxa_sva
	import mrxa_pkg::*;
(
	input wire logic              CLK,
	input wire logic              RST,
	input wire logic [19:0]       REG_ADDR,
	input wire logic [7:0]        REG_WDATA,
	input wire logic              REG_WR,
	input wire logic              REG_RD,
	input wire logic [7:0]        REG_RDATA,
	input wire logic              RX_READ_CLOCK_A,
	input wire logic              RX_READ_CLOCK_B,
	input wire logic [NCH*WW-1:0] RX_WORD_OUT,
	input wire logic [NCH-1:0]    RX_WORD_VALID,
	input wire logic              TX_CLOCK_RETURN_A,
	input wire logic [7:0]        LEGACY_POWER_DOWN,
	input wire logic [3:0]        LEGACY_GROUP_JOIN
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] mode_a_r;
	always_ff @(posedge CLK or posedge RST) begin
		if (RST)
			mode_a_r <= MODE_RST;
		else if (REG_WR && REG_ADDR == ADDR_MODE_A)
			mode_a_r <= REG_WDATA;
	end
	default clocking cb @(posedge CLK); endclocking
	default disable iff (RST);
	property p_vld_pulse;
		RX_WORD_VALID[0] |=> !RX_WORD_VALID[0];
	endproperty
	a_vld_pulse: assert property (p_vld_pulse) else $error("valid too long");
	property p_word_hold;
		$changed(RX_WORD_OUT[39:0]) |-> RX_WORD_VALID[0];
	endproperty
	a_word_hold: assert property (p_word_hold) else $error("word moved without valid");
	property p_rd_hold;
		!REG_RD |=> $stable(REG_RDATA);
	endproperty
	a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
	property p_mode_rd;
		REG_RD && !REG_WR && REG_ADDR == ADDR_MODE_A |=> REG_RDATA == mode_a_r;
	endproperty
	a_mode_rd: assert property (p_mode_rd) else $error("mode readback wrong");
	property p_leg_wr;
		REG_WR && REG_ADDR == ADDR_LEG[7] |=> LEGACY_POWER_DOWN[7] == $past(REG_WDATA[LEG_PD_BIT]);
	endproperty
	a_leg_wr: assert property (p_leg_wr) else $error("power-down bit wrong");
	property p_join;
		REG_WR && REG_ADDR == ADDR_LEGJ_B |=> LEGACY_GROUP_JOIN[3:2] == $past(REG_WDATA[LEGJ_HI:LEGJ_LO]);
	endproperty
	a_join: assert property (p_join) else $error("group join bits wrong");
	property p_tx_hold;
		$changed(TX_CLOCK_RETURN_A) |=> $stable(TX_CLOCK_RETURN_A) [*3];
	endproperty
	a_tx_hold: assert property (p_tx_hold) else $error("tx clock too fast");
	property p_rck_a;
		$rose(RX_READ_CLOCK_A) |-> ##[1:5] RX_WORD_VALID[0];
	endproperty
	a_rck_a: assert property (p_rck_a) else $error("no word on quad A edge");
	property p_rck_b;
		$rose(RX_READ_CLOCK_B) |-> ##[1:5] RX_WORD_VALID[2];
	endproperty
	a_rck_b: assert property (p_rck_b) else $error("no word on quad B edge");
	property p_vld_cause;
		RX_WORD_VALID[0] |-> $past(RX_READ_CLOCK_A, 2);
	endproperty
	a_vld_cause: assert property (p_vld_cause) else $error("word without read clock");
endmodule : mrxa_sva
bind mrxa_core mrxa_sva u_mrxa_sva (.CLK(CLK), .RST(RST), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
	.REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .RX_READ_CLOCK_A(RX_READ_CLOCK_A),
	.RX_READ_CLOCK_B(RX_READ_CLOCK_B), .RX_WORD_OUT(RX_WORD_OUT), .RX_WORD_VALID(RX_WORD_VALID),
	.TX_CLOCK_RETURN_A(TX_CLOCK_RETURN_A), .LEGACY_POWER_DOWN(LEGACY_POWER_DOWN),
	.LEGACY_GROUP_JOIN(LEGACY_GROUP_JOIN));

/* mrxa_fabric.sv */
module mrxa_fabric (
	output logic rd_clk_a,
	output logic rd_clk_b,
	output logic ref_clk_a,
	output logic ref_clk_b
);
	timeunit 1ns;
	timeprecision 1ns;
	logic rd_clk  = 1'b0;
	logic ref_clk = 1'b0;
	// One source per pair keeps reads locked to writes
	assign rd_clk_a  = rd_clk;
	assign rd_clk_b  = rd_clk;
	assign ref_clk_a = ref_clk;
	assign ref_clk_b = ref_clk;
	// Long high phase, so lanes hold well after each rise
	initial begin
		#37;
		forever begin
			rd_clk = 1'b1;
			#500;
			rd_clk = 1'b0;
			#300;
		end
	end
	initial begin
		#13;
		forever #300 ref_clk = ~ref_clk;
	end
endmodule : mrxa_fabric

/* tb_top.sv */
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	import mrxa_pkg::*;
	localparam logic [7:0] WIN = 8'h04;
	logic              clk = 1'b0;
	logic              rst = 1'b1;
	logic [19:0]       addr = '0;
	logic [7:0]        wdata = '0;
	logic              wr = 1'b0;
	logic              rd = 1'b0;
	logic [NCH*WW-1:0] raw = '0;
	logic [NCH*32-1:0] data = '0;
	logic [NCH*4-1:0]  kf = '0;
	logic [NCH*4-1:0]  cv = '0;
	logic [NCH-1:0]    ach = '0;
	logic [NCH-1:0]    ach_nxt = '0;
	logic [7:0]        rdata;
	logic [NCH*WW-1:0] word;
	logic [NCH-1:0]    vld;
	logic              tx_a;
	logic              tx_b;
	logic [7:0]        lpd;
	logic [3:0]        ljn;
	logic              rck_a, rck_b, ref_a, ref_b;
	logic [3:0]        cfg [NCH];
	logic [WW-1:0]     expq [NCH][$];
	logic [3:0]        fm [3] = '{4'h8, 4'hB, 4'h9};
	logic              exp_on = 1'b0;
	logic              chk_on = 1'b0;
	logic              tx_q = 1'b0;
	logic              tx_bq = 1'b0;
	int                errors = 0;
	int                tests_run = 0;
	int                tx_tog = 0;
	int                tx_btog = 0;
	int                n;
	int                nb;
	always #50 clk = ~clk;
	mrxa_fabric u_mrxa_fabric (.rd_clk_a(rck_a), .rd_clk_b(rck_b), .ref_clk_a(ref_a), .ref_clk_b(ref_b));
	mrxa_core #(.ALIGN_WINDOW(WIN)) u_mrxa_core (.CLK(clk), .RST(rst), .REG_ADDR(addr), .REG_WDATA(wdata),
		.REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata), .RX_READ_CLOCK_A(rck_a), .RX_READ_CLOCK_B(rck_b),
		.REF_CLOCK_A(ref_a), .REF_CLOCK_B(ref_b), .RX_RAW(raw), .RX_DATA(data), .RX_K(kf), .RX_CV(cv),
		.RX_ALIGN_CHAR(ach), .RX_WORD_OUT(word), .RX_WORD_VALID(vld), .TX_CLOCK_RETURN_A(tx_a),
		.TX_CLOCK_RETURN_B(tx_b), .LEGACY_POWER_DOWN(lpd), .LEGACY_GROUP_JOIN(ljn));
	task automatic check(input logic [WW-1:0] seen, input logic [WW-1:0] want);
		tests_run++;
		if (seen !== want) begin
			errors++;
			$display("BAD t=%0t seen=%h want=%h", $time, seen, want);
		end
	endtask : check
	task automatic wreg(input logic [19:0] a, input logic [7:0] d);
		@(negedge clk);
		addr = a;
		wdata = d;
		wr = 1'b1;
		@(negedge clk);
		wr = 1'b0;
	endtask : wreg
	task automatic rchk(input logic [19:0] a, input logic [7:0] m, input logic [7:0] want);
		@(negedge clk);
		addr = a;
		rd = 1'b1;
		@(negedge clk);
		rd = 1'b0;
		check(WW'(rdata & m), WW'(want));
	endtask : rchk
	task automatic wcfg(input int c, input logic [3:0] v);
		cfg[c] = v;
		wreg(ADDR_CFG0 + 20'(c), {4'h0, v});
	endtask : wcfg
	function automatic logic [WW-1:0] fmt(input int c);
		logic [WW-1:0] w;
		w = raw[c*WW+:WW];
		if (cfg[c][CFG_DEC])
			for (int g = 0; g < 4; g++)
				w[g*GW+:GW] = {cv[c*4+g] & cfg[c][CFG_CVSEL], kf[c*4+g], data[c*32+g*8+:8]};
		return w;
	endfunction : fmt
	// Lanes change in the low phase, far from the capturing rise
	always @(negedge rck_a) begin
		@(negedge clk);
		for (int i = 0; i < NCH*WW/32; i++)
			raw[i*32+:32] = $urandom;
		for (int i = 0; i < NCH; i++)
			data[i*32+:32] = $urandom;
		kf = 16'($urandom);
		cv = 16'($urandom);
		ach = ach_nxt;
		ach_nxt = '0;
		exp_on = chk_on;
		if (chk_on)
			for (int c = 0; c < NCH; c++)
				expq[c].push_back(fmt(c));
	end
	always @(negedge clk)
		if (exp_on)
			for (int c = 0; c < NCH; c++)
				if (vld[c] === 1'b1)
					check(word[c*WW+:WW], expq[c].size() ? expq[c].pop_front() : ~word[c*WW+:WW]);
	always @(negedge clk) begin
		if (tx_a !== tx_q)
			tx_tog++;
		tx_q = tx_a;
		if (tx_b !== tx_bq)
			tx_btog++;
		tx_bq = tx_b;
	end
	task automatic tally_and_finish();
		$display("errors=%0d tests_run=%0d", errors, tests_run);
		if (errors == 0 && tests_run > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : tally_and_finish
	initial begin
		#1_000_000;
		errors++;
		tally_and_finish();
	end
	initial begin
		void'($urandom(21));
		for (int c = 0; c < NCH; c++)
			cfg[c] = CFG_RST;
		repeat (10) @(negedge clk);
		rst = 1'b0;
		rchk(ADDR_MODE_A, 8'hFF, MODE_RST);
		rchk(ADDR_CFG0, 8'h0F, CFG_RST);
		rchk(ADDR_LEGJ_A, 8'h30, 8'h00);
		check(WW'(lpd), WW'(0));
		for (int i = 0; i < 8; i++)
			wreg(ADDR_LEG[i], 8'h02);
		check(WW'(lpd), WW'(8'hFF));
		rchk(ADDR_LEG[7], 8'h02, 8'h02);
		wreg(ADDR_LEGJ_B, 8'h30);
		check(WW'(ljn), WW'(4'hC));
		wreg(ADDR_LEGJ_B, 8'h00);
		check(WW'(ljn), WW'(4'h0));
		wreg(20'h31811, MODE_FOUR);
		rchk(20'h31811, 8'hFF, 8'h00);
		rchk(ADDR_MODE_A, 8'hFF, MODE_NONE);
		// Odd channels full rate, even half: mixing is legal unaligned
		foreach (fm[i]) begin
			chk_on = 1'b0;
			repeat (20) @(negedge clk);
			for (int c = 0; c < NCH; c++)
				wcfg(c, fm[i] | (c % 2 ? 4'h4 : 4'h0));
			chk_on = 1'b1;
			repeat (50) @(negedge clk);
		end
		chk_on = 1'b0;
		for (int s = 0; s < 2; s++) begin
			// Quads pick opposite rates to show they are independent
			wreg(ADDR_TXSRC_A, 8'(s));
			wreg(ADDR_TXSRC_B, 8'(1 - s));
			repeat (4) @(posedge ref_a);
			n = tx_tog;
			nb = tx_btog;
			repeat (16) @(posedge ref_a);
			check(WW'((tx_tog - n + 2) / 4), WW'(2 + 2 * s));
			check(WW'((tx_btog - nb + 2) / 4), WW'(4 - 2 * s));
		end
		for (int c = 0; c < NCH; c++)
			wcfg(c, CFG_RST);
		for (int s = 0; s < 5; s++) begin
			wcfg(1, s == 2 ? 4'h3 : CFG_RST);
			wreg(ADDR_MODE_A, s == 3 ? MODE_FOUR : MODE_TWIN);
			repeat (10) @(negedge clk);
			@(posedge rck_a);
			ach_nxt = s == 3 ? 4'hF : (s == 0 ? 4'h3 : 4'h1);
			// A repeat before the partner arrives overruns the group
			if (s == 4) begin
				@(posedge rck_a);
				ach_nxt = 4'h1;
			end
			repeat (80) @(negedge clk);
			rchk(ADDR_STAT_A, 8'h0F, s == 1 ? 8'h06 : (s == 4 ? 8'h07 : 8'h0C));
			check(WW'({word[39], word[29], word[19], word[9]}), WW'({s == 1 || s == 4, 1'b1, s == 3, s == 4}));
			if (s == 3)
				check(WW'(word[2*WW+29]), WW'(1));
		end
		check(WW'(expq[0].size() + expq[1].size() + expq[2].size() + expq[3].size()), WW'(0));
		tally_and_finish();
	end
endmodule : tb_top
